// ==== rtl/dchp_data_if.sv ====
// word channel between the host port and the byte packer
// assumes both ends run on the same clock
interface dchp_data_if;
  logic [15:0] rd_word;
  logic rd_valid;
  logic rd_pop;
  logic [15:0] wr_word;
  logic wr_push;
  logic wr_space;
  logic byte_mode;

  modport host (input rd_word, input rd_valid, input wr_space,
                output rd_pop, output wr_word, output wr_push, output byte_mode);
  modport pack (output rd_word, output rd_valid, output wr_space,
                input rd_pop, input wr_word, input wr_push, input byte_mode);
endinterface

// ==== rtl/dchp_decode.sv ====
// host port address decoder, purely combinational
// assumes the address is already latched for the current cycle
module dchp_decode
  import dchp_pkg::*;
(
  // address and configuration
  input wire logic [9:0] addr,
  input wire logic primary_sel,
  input wire logic floppy_config,
  // decoded selects
  output logic hit,
  output logic [3:0] port_sel,
  output logic fdc_chip,
  output logic fdc_ops,
  output logic fdc_ctrl
);
  logic [9:0] base_lo;
  logic [9:0] base_hi;
  logic in_lo;
  logic in_hi;
  logic hi_claim;

  assign base_lo = primary_sel ? PRI_BASE_LO : SEC_BASE_LO;
  assign base_hi = primary_sel ? PRI_BASE_HI : SEC_BASE_HI;
  assign in_lo = dchp_in_block(addr, base_lo);
  assign in_hi = dchp_in_block(addr, base_hi);
  assign hi_claim = in_hi && (addr[2:0] == OFS_CTRL || addr[2:0] == OFS_AUX);
  assign hit = in_lo || hi_claim;
  assign port_sel = {in_hi, addr[2:0]};
  assign fdc_chip = floppy_config && in_hi && (addr[2:0] == OFS_FDC_CHIP_A || addr[2:0] == OFS_FDC_CHIP_B);
  assign fdc_ops = floppy_config && in_hi && (addr[2:0] == OFS_FDC_OPS);
  assign fdc_ctrl = floppy_config && in_hi && (addr[2:0] == OFS_FDC_CTRL);
endmodule

// ==== rtl/dchp_pack.sv ====
// byte/word packer between the buffer byte stream and the 16-bit data port
// assumes bytes arrive low byte first; byte mode moves single low bytes
module dchp_pack
  import dchp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // word side
  dchp_data_if.pack dp,
  // buffer side, read direction
  input wire logic [7:0] rd_byte,
  input wire logic rd_byte_valid,
  output logic rd_byte_ready,
  // buffer side, write direction
  output logic [7:0] wr_byte,
  output logic wr_byte_valid,
  input wire logic wr_byte_ready
);
  logic [15:0] rd_word_r;
  logic rd_valid_r;
  logic rd_half_r;
  logic [15:0] wr_word_r;
  dchp_wr_state_t wr_state_r;
  dchp_wr_state_t wr_state_nxt;
  logic rd_take;
  logic rd_last;

  assign rd_byte_ready = !rd_valid_r && !rst;
  assign rd_take = rd_byte_ready && rd_byte_valid;
  assign rd_last = rd_half_r || dp.byte_mode;
  assign dp.rd_word = rd_word_r;
  assign dp.rd_valid = rd_valid_r;
  assign dp.wr_space = (wr_state_r == WR_IDLE) && !rst;
  assign wr_byte = (wr_state_r == WR_HIGH) ? wr_word_r[15:8] : wr_word_r[7:0];
  assign wr_byte_valid = (wr_state_r != WR_IDLE) && !rst;

  // gathering restarts at once on pop so a burst never waits more than two bytes
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_word_r <= 16'h0000;
      rd_valid_r <= 1'b0;
      rd_half_r <= 1'b0;
    end else if (ce) begin
      if (dp.rd_pop) begin
        rd_valid_r <= 1'b0;
      end else if (rd_take) begin
        if (rd_half_r) begin
          rd_word_r[15:8] <= rd_byte;
        end else begin
          rd_word_r <= {8'h00, rd_byte};
        end
        rd_half_r <= !rd_last;
        rd_valid_r <= rd_last;
      end
    end
  end

  always_comb begin
    wr_state_nxt = wr_state_r;
    unique case (wr_state_r)
      WR_IDLE: begin
        if (dp.wr_push) begin
          wr_state_nxt = WR_LOW;
        end
      end
      WR_LOW: begin
        if (wr_byte_ready) begin
          wr_state_nxt = dp.byte_mode ? WR_IDLE : WR_HIGH;
        end
      end
      WR_HIGH: begin
        if (wr_byte_ready) begin
          wr_state_nxt = WR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_state_r <= WR_IDLE;
      wr_word_r <= 16'h0000;
    end else if (ce) begin
      wr_state_r <= wr_state_nxt;
      if (dp.wr_push && wr_state_r == WR_IDLE) begin
        wr_word_r <= dp.wr_word;
      end
    end
  end
endmodule

// ==== rtl/dchp_pkg.sv ====
// constants, types and decode helpers for the disk controller host port
// assumes a 100 MHz crystal clock and a host bus sampled synchronously to it
package dchp_pkg;

  // port blocks: eight ports at the low base, two claimed at the high base
  localparam logic [9:0] PRI_BASE_LO = 10'h1F0;
  localparam logic [9:0] PRI_BASE_HI = 10'h3F0;
  localparam logic [9:0] SEC_BASE_LO = 10'h170;
  localparam logic [9:0] SEC_BASE_HI = 10'h370;

  // port offsets inside a block
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_PRECOMP = 3'h1;
  localparam logic [2:0] OFS_CTRL = 3'h6;
  localparam logic [2:0] OFS_AUX = 3'h7;
  localparam logic [2:0] OFS_FDC_OPS = 3'h2;
  localparam logic [2:0] OFS_FDC_CHIP_A = 3'h4;
  localparam logic [2:0] OFS_FDC_CHIP_B = 3'h5;
  localparam logic [2:0] OFS_FDC_CTRL = 3'h7;

  // reset values
  localparam logic [7:0] PRECOMP_RESET = 8'h20;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // control register fields
  localparam int CTRL_IRQ_OFF_BIT = 1;
  localparam int CTRL_SOFT_RST_BIT = 2;
  localparam int CTRL_MANY_HEADS_BIT = 3;
  localparam int CTRL_DMA_EN_BIT = 4;

  // timing: component reset stretched to 24 half-rate clock periods
  localparam int CLK_PERIOD_NS = 10;
  localparam int COMPONENT_RESET_OUT_MIN_NS = 480;
  localparam int COMPONENT_RESET_OUT_CYCLES = (COMPONENT_RESET_OUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] COMPONENT_RESET_OUT_LOAD = 6'(COMPONENT_RESET_OUT_CYCLES);

  typedef enum logic [1:0] {WR_IDLE, WR_LOW, WR_HIGH} dchp_wr_state_t;

  // true when an address falls in the eight-port block of a base
  function automatic logic dchp_in_block(input logic [9:0] addr, input logic [9:0] base);
    dchp_in_block = (addr[9:3] == base[9:3]);
  endfunction

endpackage

// ==== rtl/dchp_top.sv ====
// host programmed I/O port of a fixed disk controller
// assumes host strobes, address and data are synchronous to the 100 MHz clock
module dchp_top
  import dchp_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // host bus address and control
  input wire logic [9:0] host_port_address,
  input wire logic aen,
  input wire logic bale,
  input wire logic ior_n,
  input wire logic iow_n,
  // host data bus
  input wire logic [7:0] host_data_low_in,
  input wire logic [7:0] host_data_high_in,
  output logic [7:0] host_data_low_out,
  output logic [7:0] host_data_high_out,
  output logic host_data_low_oe,
  output logic host_data_high_oe,
  // host handshakes
  output logic iocs16_n,
  output logic irq14,
  output logic dreq,
  input wire logic dack_n,
  // board configuration
  input wire logic primary_sel,
  input wire logic floppy_config,
  // floppy co-controller selects
  output logic fdc_chip_select_n,
  output logic fdc_ctrl_reg_select_n,
  output logic fdc_ops_reg_select_n,
  // resets and clocks
  input wire logic host_reset_in,
  output logic component_reset_out,
  output logic half_rate_clock_out,
  output logic full_rate_clock_out,
  // controller core: task registers and events
  output logic [3:0] task_sel,
  output logic task_wr,
  output logic [7:0] task_wr_data,
  input wire logic [7:0] task_rd_data,
  input wire logic irq_request,
  input wire logic ecc_byte_mode,
  input wire logic dma_dir_read,
  // controller core: buffer byte stream
  input wire logic [7:0] rd_byte,
  input wire logic rd_byte_valid,
  output logic rd_byte_ready,
  output logic [7:0] wr_byte,
  output logic wr_byte_valid,
  input wire logic wr_byte_ready,
  // drive write control
  input wire logic write_req,
  input wire logic [10:0] cylinder,
  output logic write_gate,
  output logic precomp_enable_out
);

  ////////////////////////////////////////////////////////////////////////////
  // reset and cycle framing

  logic rst_any;
  logic bale_d_r;
  logic ior_d_r;
  logic iow_d_r;
  logic [9:0] cyc_addr_r;
  logic cyc_pio_r;
  logic bale_rise;
  logic ior_rise;
  logic iow_rise;

  // host reset acts like the local reset, except that only the local reset clears the half-rate clock divider
  assign rst_any = reset || host_reset_in;
  assign bale_rise = bale && !bale_d_r;
  assign ior_rise = ior_n && !ior_d_r;
  assign iow_rise = iow_n && !iow_d_r;

  always_ff @(posedge clk) begin
    if (rst_any) begin
      bale_d_r <= 1'b0;
      ior_d_r <= 1'b1;
      iow_d_r <= 1'b1;
      cyc_addr_r <= 10'h000;
      cyc_pio_r <= 1'b0;
    end else if (ce) begin
      bale_d_r <= bale;
      ior_d_r <= ior_n;
      iow_d_r <= iow_n;
      if (bale_rise) begin
        cyc_addr_r <= host_port_address;
        cyc_pio_r <= !aen;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  logic dec_hit;
  logic [3:0] dec_sel;
  logic dec_fdc_chip;
  logic dec_fdc_ops;
  logic dec_fdc_ctrl;
  logic pio_hit;
  logic dma_cycle;
  logic sel_data;
  logic sel_precomp;
  logic sel_ctrl;
  logic sel_task;

  dchp_decode u_decode (
    .addr(cyc_addr_r),
    .primary_sel(primary_sel),
    .floppy_config(floppy_config),
    .hit(dec_hit),
    .port_sel(dec_sel),
    .fdc_chip(dec_fdc_chip),
    .fdc_ops(dec_fdc_ops),
    .fdc_ctrl(dec_fdc_ctrl)
  );

  // a DMA cycle reaches only the data port, and only when acknowledged
  assign pio_hit = cyc_pio_r && dec_hit;
  assign dma_cycle = aen && !dack_n;
  assign sel_data = (pio_hit && dec_sel == {1'b0, OFS_DATA}) || dma_cycle;
  assign sel_precomp = pio_hit && dec_sel == {1'b0, OFS_PRECOMP};
  assign sel_ctrl = pio_hit && dec_sel == {1'b1, OFS_CTRL};
  assign sel_task = pio_hit && !sel_data && !sel_precomp && !sel_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // packer

  dchp_data_if dp_if ();

  dchp_pack u_pack (
    .clk(clk),
    .rst(rst_any),
    .ce(ce),
    .dp(dp_if.pack),
    .rd_byte(rd_byte),
    .rd_byte_valid(rd_byte_valid),
    .rd_byte_ready(rd_byte_ready),
    .wr_byte(wr_byte),
    .wr_byte_valid(wr_byte_valid),
    .wr_byte_ready(wr_byte_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // host reads

  logic rd_active;
  logic [15:0] rd_data_r;
  logic rd_oe_r;
  logic rd_wide_r;
  logic [7:0] port_rd_byte;

  assign rd_active = !ior_n && (pio_hit || dma_cycle) && !rst_any;
  assign port_rd_byte = task_rd_data;
  assign task_sel = dec_sel;
  assign dp_if.byte_mode = ecc_byte_mode;
  // the word is consumed when the strobe ends, so a held strobe reads it steadily
  assign dp_if.rd_pop = ior_rise && sel_data && dp_if.rd_valid;

  always_ff @(posedge clk) begin
    if (rst_any) begin
      rd_data_r <= 16'h0000;
      rd_oe_r <= 1'b0;
      rd_wide_r <= 1'b0;
    end else if (ce) begin
      rd_oe_r <= rd_active;
      rd_wide_r <= rd_active && sel_data && !ecc_byte_mode;
      if (rd_active) begin
        rd_data_r <= sel_data ? dp_if.rd_word : {8'h00, port_rd_byte};
      end
    end
  end

  assign host_data_low_out = rd_data_r[7:0];
  assign host_data_high_out = rd_data_r[15:8];
  assign host_data_low_oe = rd_oe_r;
  assign host_data_high_oe = rd_oe_r && rd_wide_r;

  ////////////////////////////////////////////////////////////////////////////
  // host writes and port registers

  logic [15:0] wr_lat_r;
  logic [7:0] precomp_r;
  logic [7:0] ctrl_r;
  logic task_wr_r;
  logic [7:0] task_wr_data_r;
  logic wr_commit;

  // bus data is held while the strobe is low and committed on its rising edge
  assign wr_commit = iow_rise && (pio_hit || dma_cycle);
  assign dp_if.wr_word = wr_lat_r;
  assign dp_if.wr_push = wr_commit && sel_data;

  always_ff @(posedge clk) begin
    if (rst_any) begin
      wr_lat_r <= 16'h0000;
      precomp_r <= PRECOMP_RESET;
      ctrl_r <= CTRL_RESET;
      task_wr_r <= 1'b0;
      task_wr_data_r <= 8'h00;
    end else if (ce) begin
      task_wr_r <= wr_commit && sel_task;
      if (!iow_n) begin
        wr_lat_r <= {ecc_byte_mode ? 8'h00 : host_data_high_in, host_data_low_in};
      end
      if (wr_commit && sel_precomp) begin
        precomp_r <= wr_lat_r[7:0];
      end
      if (wr_commit && sel_ctrl) begin
        ctrl_r <= wr_lat_r[7:0];
      end
      if (wr_commit && sel_task) begin
        task_wr_data_r <= wr_lat_r[7:0];
      end
    end
  end

  assign task_wr = task_wr_r;
  assign task_wr_data = task_wr_data_r;

  ////////////////////////////////////////////////////////////////////////////
  // handshakes to the host

  logic irq_r;

  // 16-bit select is combinational so the host sees it early in the cycle
  assign iocs16_n = !(pio_hit && sel_data && !ecc_byte_mode && !rst_any);
  assign dreq = ctrl_r[CTRL_DMA_EN_BIT] && !rst_any
                && (dma_dir_read ? dp_if.rd_valid : dp_if.wr_space);

  always_ff @(posedge clk) begin
    if (rst_any) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= irq_request && !ctrl_r[CTRL_IRQ_OFF_BIT];
    end
  end

  assign irq14 = irq_r;

  // floppy chip select follows both host strobes of a decoded cycle, the register selects only the write strobe
  logic host_strobe;
  assign host_strobe = cyc_pio_r && (!ior_n || !iow_n) && !rst_any;
  assign fdc_chip_select_n = !(host_strobe && dec_fdc_chip);
  assign fdc_ops_reg_select_n = !(host_strobe && !iow_n && dec_fdc_ops);
  assign fdc_ctrl_reg_select_n = !(host_strobe && !iow_n && dec_fdc_ctrl);

  ////////////////////////////////////////////////////////////////////////////
  // component reset and clocks

  logic [5:0] rst_cnt_r;
  logic half_clk_r;

  // stretched so slow parts on the board see a long enough pulse
  always_ff @(posedge clk) begin
    if (rst_any) begin
      rst_cnt_r <= COMPONENT_RESET_OUT_LOAD;
    end else if (ce) begin
      if (ctrl_r[CTRL_SOFT_RST_BIT]) begin
        rst_cnt_r <= COMPONENT_RESET_OUT_LOAD;
      end else if (rst_cnt_r != 6'h00) begin
        rst_cnt_r <= rst_cnt_r - 6'h01;
      end
    end
  end

  assign component_reset_out = host_reset_in || rst_cnt_r != 6'h00;

  always_ff @(posedge clk) begin
    if (reset) begin
      half_clk_r <= 1'b0;
    end else if (ce) begin
      half_clk_r <= !half_clk_r;
    end
  end

  assign half_rate_clock_out = half_clk_r;
  // forwarded crystal clock; a gated copy would break the duty cycle
  assign full_rate_clock_out = clk;

  ////////////////////////////////////////////////////////////////////////////
  // write gate and reduced write current

  logic write_gate_r;
  logic precomp_r_en;
  logic above_threshold;

  assign above_threshold = cylinder >= {1'b0, precomp_r, 2'b00};

  always_ff @(posedge clk) begin
    if (rst_any) begin
      write_gate_r <= 1'b0;
      precomp_r_en <= 1'b0;
    end else if (ce) begin
      write_gate_r <= write_req;
      precomp_r_en <= write_req && above_threshold && !ctrl_r[CTRL_MANY_HEADS_BIT];
    end
  end

  assign write_gate = write_gate_r;
  assign precomp_enable_out = precomp_r_en && write_gate_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_cs16_data_only: assert property (!iocs16_n |-> sel_data && cyc_pio_r)
    else $error("16-bit select outside the data port");
  a_cs16_wide: assert property (!iocs16_n && !ior_n && ce |=> host_data_high_oe)
    else $error("16-bit read without high byte drive");
  a_rd_drive: assert property (ce && rd_active |=> host_data_low_oe)
    else $error("read strobe not answered with bus drive");
  a_no_drive_aen: assert property (aen && dack_n && ce |=> !host_data_low_oe)
    else $error("bus driven during unacknowledged dma cycle");
  a_precomp_gated: assert property (precomp_enable_out |-> write_gate)
    else $error("reduced current without write gate");
  a_precomp_reset: assert property (host_reset_in ##1 !host_reset_in |-> precomp_r == PRECOMP_RESET)
    else $error("threshold register not reset to 20H");
  a_precomp_hold: assert property (!(wr_commit && sel_precomp) && !rst_any |=> $stable(precomp_r))
    else $error("threshold register changed without a write");
  a_component_reset_out_host: assert property (host_reset_in |-> component_reset_out ##1 component_reset_out)
    else $error("component reset not driven on host reset");
  a_irq_reset: assert property (host_reset_in |=> !irq14)
    else $error("interrupt request held through host reset");
  a_half_clock: assert property (ce && !reset |=> half_rate_clock_out != $past(half_rate_clock_out))
    else $error("half-rate clock did not toggle");
  a_cycle_latch: assert property (bale_rise && ce && !rst_any |=> cyc_addr_r == $past(host_port_address))
    else $error("cycle address not latched on latch enable rise");

  c_word_read: cover property (!iocs16_n && ior_rise && dp_if.rd_pop);
  c_word_write: cover property (dp_if.wr_push ##[1:20] wr_byte_valid && wr_byte_ready);
  c_precomp_on: cover property (precomp_enable_out);
  c_soft_reset: cover property (wr_commit && sel_ctrl && wr_lat_r[CTRL_SOFT_RST_BIT]);

endmodule

// ==== sim/dchp_host_model.sv ====
// host expansion bus processor model: issues port reads and writes
// assumes the port samples every strobe on the rising clock edge
module dchp_host_model (
  // clock
  input wire logic clk,
  // bus driven by the host
  output logic [9:0] host_port_address,
  output logic aen,
  output logic bale,
  output logic ior_n,
  output logic iow_n,
  output logic [15:0] data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    host_port_address = 10'h000;
    aen = 1'b0;
    bale = 1'b0;
    ior_n = 1'b1;
    iow_n = 1'b1;
    data = 16'h0000;
  end

  // one cycle: latch pulse, strobe low for n cycles, then one quiet cycle
  task automatic cycle(input logic [9:0] a, input logic dma, input logic wr, input logic [15:0] d, input int n);
    @(posedge clk);
    host_port_address <= a;
    aen <= dma;
    bale <= 1'b1;
    @(posedge clk);
    bale <= 1'b0;
    data <= d;
    if (wr) begin
      iow_n <= 1'b0;
    end else begin
      ior_n <= 1'b0;
    end
    repeat (n) @(posedge clk);
    iow_n <= 1'b1;
    ior_n <= 1'b1;
    @(posedge clk);
    // a released bus must not keep looking like the written word
    data <= ~d;
  endtask
endmodule

// ==== sim/dchp_top_tb.sv ====
// self-checking bench for the disk controller host port
// assumes the host model drives the bus and this module plays the buffer side
module dchp_top_tb
  import dchp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0, reset = 1'b1, ce = 1'b1, dack_n = 1'b1;
  logic [9:0] host_port_address;
  logic aen, bale, ior_n, iow_n;
  wire [7:0] host_data_low_in, host_data_high_in;
  logic [7:0] host_data_low_out, host_data_high_out, task_wr_data, wr_byte;
  logic host_data_low_oe, host_data_high_oe, iocs16_n, irq14, dreq, task_wr, wr_byte_valid;
  logic fdc_chip_select_n, fdc_ctrl_reg_select_n, fdc_ops_reg_select_n, rd_byte_ready;
  logic primary_sel = 1'b1, floppy_config = 1'b1, host_reset_in = 1'b0;
  logic component_reset_out, half_rate_clock_out, full_rate_clock_out, write_gate, precomp_enable_out;
  logic [3:0] task_sel;
  logic [7:0] task_rd_data = 8'h00, rd_byte = 8'h00, t;
  logic irq_request = 1'b0, ecc_byte_mode = 1'b0, dma_dir_read = 1'b0, rd_byte_valid = 1'b0;
  logic wr_byte_ready = 1'b1, write_req = 1'b0, oe_q = 1'b0, hc;
  logic [10:0] cylinder = 11'h000;
  logic [15:0] d;
  logic [9:0] b, o;
  logic [15:0] exp_q[$];
  logic [7:0] src[$];
  int seed = 70, n_errors = 0, checks = 0, fcnt = 0, prev;

  always #5 clk = ~clk;

  dchp_host_model h (.clk, .host_port_address, .aen, .bale, .ior_n, .iow_n,
    .data({host_data_high_in, host_data_low_in}));

  dchp_top uut (.clk, .reset, .ce, .host_port_address, .aen, .bale, .ior_n, .iow_n,
    .host_data_low_in, .host_data_high_in, .host_data_low_out, .host_data_high_out,
    .host_data_low_oe, .host_data_high_oe, .iocs16_n, .irq14, .dreq, .dack_n, .primary_sel,
    .floppy_config, .fdc_chip_select_n, .fdc_ctrl_reg_select_n, .fdc_ops_reg_select_n,
    .host_reset_in, .component_reset_out, .half_rate_clock_out, .full_rate_clock_out,
    .task_sel, .task_wr, .task_wr_data, .task_rd_data, .irq_request, .ecc_byte_mode,
    .dma_dir_read, .rd_byte, .rd_byte_valid, .rd_byte_ready, .wr_byte, .wr_byte_valid,
    .wr_byte_ready, .write_req, .cylinder, .write_gate, .precomp_enable_out);

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // an empty queue yields FFFF for a zero result and zero otherwise, so a stray result always mismatches
  task automatic note(input logic [15:0] seen);
    logic [15:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : ((seen === 16'h0000) ? 16'hFFFF : 16'h0000);
    check("result", seen, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic ctl(input logic [7:0] v);
    h.cycle({PRI_BASE_HI[9:3], OFS_CTRL}, 1'b0, 1'b1, {8'h00, v}, 1);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (task_wr) note({8'h00, task_wr_data});
    if (wr_byte_valid && wr_byte_ready) note({8'h00, wr_byte});
    if (host_data_low_oe && !oe_q) note({host_data_high_oe ? host_data_high_out : 8'h00, host_data_low_out});
    oe_q <= host_data_low_oe;
    wr_byte_ready <= 1'($random(seed));
    fcnt <= fcnt + (!fdc_chip_select_n || !fdc_ops_reg_select_n || !fdc_ctrl_reg_select_n);
  end

  always @(posedge clk) begin
    if (!rd_byte_valid || rd_byte_ready) begin
      rd_byte_valid <= src.size() > 0;
      if (src.size() > 0) rd_byte <= src.pop_front();
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("[ERR] run limit expected end seen hang");
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    tick(40);
    check("rst_out held", component_reset_out, 1'b1);
    check("irq idle", irq14, 1'b0);
    tick(20);
    check("rst_out done", component_reset_out, 1'b0);
    hc = half_rate_clock_out;
    tick(1);
    check("half clock", half_rate_clock_out, !hc);
    check("full clock", full_rate_clock_out, clk);
    $display("test reset done");
    for (int p = 1; p >= 0; p--) begin
      @(posedge clk);
      primary_sel <= p[0];
      b = p ? PRI_BASE_LO : SEC_BASE_LO;
      o = p ? SEC_BASE_LO : PRI_BASE_LO;
      d = 16'($random(seed));
      exp_q.push_back({8'h00, d[7:0]});
      h.cycle(b + 10'h003, 1'b0, 1'b1, d, 1);
      h.cycle(o + 10'h003, 1'b0, 1'b1, d, 2);
      h.cycle(b + 10'h003, 1'b1, 1'b1, d, 1);
      task_rd_data <= d[15:8];
      exp_q.push_back({8'h00, d[15:8]});
      h.cycle(b + 10'h003, 1'b0, 1'b0, d, 1);
      tick(1);
      check("iocs16 byte port", iocs16_n, 1'b1);
      check("task select", {12'h000, task_sel}, 16'h0003);
      src.push_back(d[15:8]);
      src.push_back(d[7:0]);
      tick(4);
      exp_q.push_back({d[7:0], d[15:8]});
      h.cycle(b, 1'b0, 1'b0, d, 3);
      tick(1);
      check("iocs16 data port", iocs16_n, 1'b0);
      exp_q.push_back({8'h00, d[7:0]});
      exp_q.push_back({8'h00, d[15:8]});
      h.cycle(b, 1'b0, 1'b1, d, 1);
      tick(10);
      $display("test decode %0d done", p);
    end
    primary_sel <= 1'b1;
    ecc_byte_mode <= 1'b1;
    src.push_back(d[7:0]);
    exp_q.push_back({8'h00, d[7:0]});
    tick(4);
    h.cycle(PRI_BASE_LO, 1'b0, 1'b0, d, 1);
    tick(1);
    check("iocs16 ecc byte", iocs16_n, 1'b1);
    ecc_byte_mode <= 1'b0;
    $display("test ecc byte done");
    write_req <= 1'b1;
    cylinder <= 11'h080;
    tick(4);
    check("write gate", write_gate, 1'b1);
    check("default threshold", precomp_enable_out, 1'b1);
    t = 8'($random(seed)) | 8'h41;
    h.cycle({PRI_BASE_LO[9:3], OFS_PRECOMP}, 1'b0, 1'b1, {8'h00, t}, 1);
    cylinder <= {1'b0, t, 2'b00} - 11'h001;
    tick(4);
    check("below threshold", precomp_enable_out, 1'b0);
    cylinder <= {1'b0, t, 2'b00};
    tick(4);
    check("at threshold", precomp_enable_out, 1'b1);
    ctl(8'h08);
    tick(3);
    check("many heads", precomp_enable_out, 1'b0);
    ctl(8'h00);
    write_req <= 1'b0;
    tick(4);
    check("gated enable", precomp_enable_out, 1'b0);
    check("write gate off", write_gate, 1'b0);
    $display("test precomp done");
    irq_request <= 1'b1;
    tick(3);
    check("irq", irq14, 1'b1);
    ctl(8'h02);
    tick(2);
    check("irq masked", irq14, 1'b0);
    ctl(8'h10);
    tick(2);
    check("irq unmasked", irq14, 1'b1);
    check("dma request", dreq, 1'b1);
    dack_n <= 1'b0;
    exp_q.push_back({8'h00, t});
    exp_q.push_back(16'h00A5);
    h.cycle(10'h000, 1'b1, 1'b1, {8'hA5, t}, 1);
    dack_n <= 1'b1;
    for (int i = 0; i < 50 && exp_q.size() > 0; i++) @(posedge clk);
    ctl(8'h04);
    tick(2);
    check("soft reset", component_reset_out, 1'b1);
    ctl(8'h00);
    host_reset_in <= 1'b1;
    write_req <= 1'b1;
    cylinder <= 11'h080;
    tick(3);
    check("irq in reset", irq14, 1'b0);
    check("gate in reset", write_gate, 1'b0);
    check("rst_out host", component_reset_out, 1'b1);
    host_reset_in <= 1'b0;
    tick(4);
    check("threshold reloaded", precomp_enable_out, 1'b1);
    $display("test control done");
    for (int f = 1; f >= 0; f--) begin
      floppy_config <= f[0];
      prev = fcnt;
      h.cycle({PRI_BASE_HI[9:3], OFS_FDC_OPS}, 1'b0, 1'b1, 16'h0000, 1);
      h.cycle({PRI_BASE_HI[9:3], OFS_FDC_CHIP_A}, 1'b0, 1'b1, 16'h0000, 1);
      tick(1);
      check("floppy selects", fcnt > prev, f[0]);
    end
    $display("test floppy done");
    for (int i = 0; i < 50 && exp_q.size() > 0; i++) @(posedge clk);
    check("pending results", 16'(exp_q.size()), 16'h0000);
    end_of_test();
  end
endmodule
